// ==== ocp_params.svh ====
// Constants for the optional configuration pin controller
`ifndef OCP_PARAMS_SVH
`define OCP_PARAMS_SVH
`define OCP_NUM_IO 8
`define OCP_IO_W 3
`define OCP_ADDR_W 8
`define OCP_OFF_CTRL 8'h00
`define OCP_OFF_STATUS 8'h04
`define OCP_OFF_IO_OUT 8'h08
`define OCP_OFF_IO_OE 8'h0c
`define OCP_OFF_USER 8'h10
`define OCP_CTRL_RESET 32'h0000_0000
`define OCP_BIT_EN_STARTCLK 0
`define OCP_BIT_EN_DONE_PIN 1
`define OCP_BIT_EN_CAL_GATE 2
`define OCP_BIT_EN_GOE 3
`define OCP_BIT_EN_GCLR 4
`define OCP_BIT_SERIAL_SRC 5
`define OCP_BIT_DATA_LOADED 6
`define OCP_BIT_INIT_GO 7
`define OCP_CTRL_W 8
`define OCP_INIT_CYCLES 8'h10
`define OCP_DIV_HALF 4'h4
`endif

// ==== ocp_pkg.sv ====
// Types for the optional configuration pin controller
package ocp_pkg;
  typedef enum logic [1:0] {
    OCP_ST_UNCONF,
    OCP_ST_LOADED,
    OCP_ST_INIT,
    OCP_ST_USER
  } ocp_state_t;
endpackage

// ==== ocp_sync.sv ====
// Two-flop synchroniser for the global override inputs
`timescale 1ns/1ns
module ocp_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic meta_d;
  logic out_q;
  logic out_d;

  always_comb begin
    meta_d = din;
    out_d = meta_q;
  end

  // Inputs idle high: reset value 1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      out_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ==== ocp_ctrl.sv ====
// Optional configuration pin controller with APB register access
// How it works
// - Disabled optional pin other than the done pin behaves as general user I/O.
// - During configuration disabled optional pins are tri-stated, weakly pulled up.
// - Start-up clock option on: initialization advances on start-up clock.
// - Serial config clock derived from start-up clock when source selects it.
// - Done output reports initialization finished, user mode entered.
// - Config request low: done output left undriven.
// - After option bit loaded, done output driven low.
// - On completion done output released high, user mode entered.
// - Calibration gating on: release waits for calibration complete.
// - Calibration gating off: release ignores calibration status.
// - Output enable input low and enabled: the eight general I/O high impedance; optional pins used as user I/O keep their enables.
// - Output enable input high: I/O follows programmed enables.
// - Clear input low and enabled: user register held cleared.
// - Clear input high: registers operate normally.
`timescale 1ns/1ns
`include "ocp_params.svh"
module ocp_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic config_request_n,
  input wire logic termination_cal_complete,
  input wire logic user_startup_clock_in,
  output logic user_startup_clock_oe_n,
  output logic init_done_out,
  output logic init_done_oe_n,
  input wire logic global_output_enable_in,
  output logic global_output_enable_oe_n,
  input wire logic global_register_clear_n_in,
  output logic global_register_clear_n_oe_n,
  output logic serial_config_clock,
  output logic pullup_en,
  output logic [7:0] io_out,
  output logic [7:0] io_oe_n,
  output logic user_mode
);
  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] io_out_reg_q, io_out_reg_d;
  logic [7:0] io_en_reg_q, io_en_reg_d;
  logic [7:0] user_reg_q, user_reg_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  ocp_pkg::ocp_state_t state_q, state_d;
  logic [7:0] init_cnt_q, init_cnt_d;
  logic clk_prev_q, clk_prev_d;
  logic [3:0] div_q, div_d;
  logic sclk_q, sclk_d;
  logic done_oe_n_q, done_oe_n_d;
  logic uclk_oe_n_q, uclk_oe_n_d;
  logic goe_oe_n_q, goe_oe_n_d;
  logic gclr_oe_n_q, gclr_oe_n_d;
  logic pull_q, pull_d;
  logic [7:0] io_out_q, io_out_d;
  logic [7:0] io_oe_n_q, io_oe_n_d;
  logic user_q, user_d;
  logic goe_s, gclr_s;
  logic clr_act, hiz_act, startclk_edge, init_tick, wr_en, rd_en;

  ocp_sync u_sync_goe (
    .clk(clk),
    .reset_n(reset_n),
    .din(global_output_enable_in),
    .dout(goe_s)
  );
  ocp_sync u_sync_gclr (
    .clk(clk),
    .reset_n(reset_n),
    .din(global_register_clear_n_in),
    .dout(gclr_s)
  );

  function automatic logic opt(input logic [7:0] c, input int b);
    opt = c[b];
  endfunction

  // ****************************************
  // Override decode
  // ****************************************
  always_comb begin
    clr_act = opt(ctrl_q, `OCP_BIT_EN_GCLR) && !gclr_s;
    hiz_act = opt(ctrl_q, `OCP_BIT_EN_GOE) && !goe_s;
    startclk_edge = user_startup_clock_in && !clk_prev_q;
    init_tick = opt(ctrl_q, `OCP_BIT_EN_STARTCLK) ? startclk_edge : 1'b1;
    wr_en = psel && penable && pwrite;
    rd_en = psel && !penable && !pwrite;
  end

  // ****************************************
  // APB slave
  // ****************************************
  always_comb begin
    ctrl_d = ctrl_q;
    io_out_reg_d = io_out_reg_q;
    io_en_reg_d = io_en_reg_q;
    user_reg_d = user_reg_q;
    prdata_d = prdata_q;
    pready_d = psel && !penable;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pslverr_d = !(paddr == `OCP_OFF_CTRL || paddr == `OCP_OFF_STATUS ||
                    paddr == `OCP_OFF_IO_OUT || paddr == `OCP_OFF_IO_OE ||
                    paddr == `OCP_OFF_USER);
    end
    if (rd_en) begin
      unique case (paddr)
        `OCP_OFF_CTRL: prdata_d = {24'h00_0000, ctrl_q};
        `OCP_OFF_STATUS: prdata_d = {26'h000_0000, gclr_s, goe_s,
                                    termination_cal_complete,
                                    config_request_n, state_q};
        `OCP_OFF_IO_OUT: prdata_d = {24'h00_0000, io_out_reg_q};
        `OCP_OFF_IO_OE: prdata_d = {24'h00_0000, io_en_reg_q};
        `OCP_OFF_USER: prdata_d = {24'h00_0000, user_reg_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_en && pready_q) begin
      unique case (paddr)
        `OCP_OFF_CTRL: ctrl_d = pwdata[7:0];
        `OCP_OFF_IO_OUT: io_out_reg_d = pwdata[7:0];
        `OCP_OFF_IO_OE: io_en_reg_d = pwdata[7:0];
        `OCP_OFF_USER: user_reg_d = pwdata[7:0];
        default: ;
      endcase
    end
    if (clr_act) begin
      user_reg_d = 8'h00;
    end
  end

  // ****************************************
  // Initialization sequence
  // ****************************************
  always_comb begin
    state_d = state_q;
    init_cnt_d = init_cnt_q;
    clk_prev_d = user_startup_clock_in;
    if (!config_request_n) begin
      state_d = ocp_pkg::OCP_ST_UNCONF;
      init_cnt_d = 8'h00;
    end else begin
      unique case (state_q)
        ocp_pkg::OCP_ST_UNCONF: begin
          if (opt(ctrl_q, `OCP_BIT_DATA_LOADED)) begin
            state_d = ocp_pkg::OCP_ST_LOADED;
          end
        end
        ocp_pkg::OCP_ST_LOADED: begin
          if (opt(ctrl_q, `OCP_BIT_INIT_GO)) begin
            state_d = ocp_pkg::OCP_ST_INIT;
          end
        end
        ocp_pkg::OCP_ST_INIT: begin
          if (init_tick && init_cnt_q != `OCP_INIT_CYCLES) begin
            init_cnt_d = init_cnt_q + 8'h01;
          end
          if (init_cnt_q == `OCP_INIT_CYCLES &&
              (!opt(ctrl_q, `OCP_BIT_EN_CAL_GATE) ||
               termination_cal_complete)) begin
            state_d = ocp_pkg::OCP_ST_USER;
          end
        end
        ocp_pkg::OCP_ST_USER: ;
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_comb begin
    div_d = div_q;
    sclk_d = sclk_q;
    if (opt(ctrl_q, `OCP_BIT_SERIAL_SRC)) begin
      sclk_d = user_startup_clock_in;
    end else if (div_q == `OCP_DIV_HALF) begin
      div_d = 4'h0;
      sclk_d = !sclk_q;
    end else begin
      div_d = div_q + 4'h1;
    end
    done_oe_n_d = 1'b1;
    // low after load, released at done
    if (config_request_n && opt(ctrl_q, `OCP_BIT_EN_DONE_PIN) &&
        state_q != ocp_pkg::OCP_ST_UNCONF &&
        state_q != ocp_pkg::OCP_ST_USER) begin
      done_oe_n_d = 1'b0;
    end
    uclk_oe_n_d = !(state_q == ocp_pkg::OCP_ST_USER &&
                    !opt(ctrl_q, `OCP_BIT_EN_STARTCLK) && io_en_reg_q[0]);
    goe_oe_n_d = !(state_q == ocp_pkg::OCP_ST_USER &&
                   !opt(ctrl_q, `OCP_BIT_EN_GOE) && io_en_reg_q[1]);
    gclr_oe_n_d = !(state_q == ocp_pkg::OCP_ST_USER &&
                    !opt(ctrl_q, `OCP_BIT_EN_GCLR) && io_en_reg_q[2]);
    pull_d = state_q != ocp_pkg::OCP_ST_USER;
    io_out_d = io_out_reg_q;
    io_oe_n_d = ~io_en_reg_q;
    if (hiz_act || state_q != ocp_pkg::OCP_ST_USER) begin
      io_oe_n_d = 8'hff;
    end
    user_d = state_q == ocp_pkg::OCP_ST_USER;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `OCP_CTRL_W'(`OCP_CTRL_RESET);
      io_out_reg_q <= 8'h00;
      io_en_reg_q <= 8'h00;
      user_reg_q <= 8'h00;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      state_q <= ocp_pkg::OCP_ST_UNCONF;
      init_cnt_q <= 8'h00;
      clk_prev_q <= 1'b0;
      div_q <= 4'h0;
      sclk_q <= 1'b0;
      done_oe_n_q <= 1'b1;
      uclk_oe_n_q <= 1'b1;
      goe_oe_n_q <= 1'b1;
      gclr_oe_n_q <= 1'b1;
      pull_q <= 1'b1;
      io_out_q <= 8'h00;
      io_oe_n_q <= 8'hff;
      user_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      io_out_reg_q <= io_out_reg_d;
      io_en_reg_q <= io_en_reg_d;
      user_reg_q <= user_reg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      state_q <= state_d;
      init_cnt_q <= init_cnt_d;
      clk_prev_q <= clk_prev_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      done_oe_n_q <= done_oe_n_d;
      uclk_oe_n_q <= uclk_oe_n_d;
      goe_oe_n_q <= goe_oe_n_d;
      gclr_oe_n_q <= gclr_oe_n_d;
      pull_q <= pull_d;
      io_out_q <= io_out_d;
      io_oe_n_q <= io_oe_n_d;
      user_q <= user_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign user_startup_clock_oe_n = uclk_oe_n_q;
  assign init_done_out = 1'b0;
  assign init_done_oe_n = done_oe_n_q;
  assign global_output_enable_oe_n = goe_oe_n_q;
  assign global_register_clear_n_oe_n = gclr_oe_n_q;
  assign serial_config_clock = sclk_q;
  assign pullup_en = pull_q;
  assign io_out = io_out_q;
  assign io_oe_n = io_oe_n_q;
  assign user_mode = user_q;
endmodule

// ==== ocp_ctrl_props.sv ====
// Port assertions for the optional configuration pin controller
`timescale 1ns/1ns
module ocp_ctrl_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic config_request_n,
  input wire logic init_done_out,
  input wire logic init_done_oe_n,
  input wire logic user_startup_clock_oe_n,
  input wire logic pullup_en,
  input wire logic user_mode
);
  // ****
  // Relations
  // ****
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_req_held;
    $fell(config_request_n) ##1 !config_request_n [*5];
  endsequence
  property p_ready_next; s_setup |=> pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_done_low;
    !init_done_oe_n |-> init_done_out == 1'b0 && !user_mode;
  endproperty
  property p_req_held; s_req_held |-> init_done_oe_n && !user_mode; endproperty
  property p_pullup;
    !user_mode |-> pullup_en && user_startup_clock_oe_n;
  endproperty
  property p_user_rel; user_mode |-> init_done_oe_n; endproperty
  property p_rel_user;
    $rose(init_done_oe_n) && config_request_n |-> user_mode;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("late pready");
  a_ready_once: assert property (p_ready_once) else $error("long pready");
  a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
  a_done_low: assert property (p_done_low) else $error("done data high");
  a_req_held: assert property (p_req_held) else $error("done driven");
  a_pullup: assert property (p_pullup) else $error("no pull-up");
  a_user_rel: assert property (p_user_rel) else $error("done held");
  a_rel_user: assert property (p_rel_user) else $error("early done");
endmodule
bind ocp_ctrl ocp_ctrl_props props_u (.clk, .reset_n, .psel, .penable,
  .pready, .pslverr, .config_request_n, .init_done_out, .init_done_oe_n,
  .user_startup_clock_oe_n, .pullup_en, .user_mode);

// ==== ocp_board.sv ====
// Board model: start-up clock source and done line monitor
`timescale 1ns/1ns
module ocp_board (
  input wire logic clk,
  input wire logic run,
  input wire logic idle_lvl,
  input wire logic init_done_oe_n,
  input wire logic init_done_out,
  output logic startup_clk,
  output logic done_seen
);
  logic [1:0] div_q = 2'h0;
  logic last_q = 1'b1;
  logic done_wire;
  initial startup_clk = 1'b0;
  initial done_seen = 1'b0;
  always @(posedge clk) begin
    div_q <= (run && div_q != 2'h2) ? div_q + 2'h1 : 2'h0;
    if (!run)
      startup_clk <= idle_lvl;
    else if (div_q == 2'h2)
      startup_clk <= ~startup_clk;
  end
  // Open-drain line with pull-up
  assign done_wire = init_done_oe_n ? 1'b1 : init_done_out;
  always @(posedge clk) begin
    last_q <= done_wire;
    if (!done_wire)
      done_seen <= 1'b0;
    else if (!last_q)
      done_seen <= 1'b1;
  end
endmodule

// ==== optional_config_pin_control_bench.sv ====
// Self-checking bench for the optional configuration pin controller
`timescale 1ns/1ns
`include "ocp_params.svh"
module optional_config_pin_control_bench;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, io_out, io_oe_n;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, config_request_n = 1, termination_cal_complete = 0;
  logic global_output_enable_in = 1, global_register_clear_n_in = 1;
  logic run = 0, idle_lvl = 0, user_startup_clock_in, done_seen;
  logic user_startup_clock_oe_n, init_done_out, init_done_oe_n;
  logic serial_config_clock, pullup_en, user_mode;
  logic global_output_enable_oe_n, global_register_clear_n_oe_n;
  int num_errors = 0, num_checks = 0;
  always #5 clk = ~clk;
  ocp_ctrl dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .config_request_n, .termination_cal_complete,
    .user_startup_clock_in, .user_startup_clock_oe_n, .init_done_out,
    .init_done_oe_n, .global_output_enable_in, .global_output_enable_oe_n,
    .global_register_clear_n_in, .global_register_clear_n_oe_n,
    .serial_config_clock, .pullup_en, .io_out, .io_oe_n, .user_mode);
  ocp_board board_u (.clk, .run, .idle_lvl, .init_done_oe_n, .init_done_out,
    .startup_clk(user_startup_clock_in), .done_seen);
  // ****
  // Helpers
  // ****
  task automatic ck(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      num_errors++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic e);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    ck("ready_err", {30'h0, 1'b1, e}, {30'h0, pready, pslverr});
    if (!wr)
      ck("prdata", d, prdata);
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [31:0] stat(input logic [1:0] st);
    return {26'h0, global_register_clear_n_in, global_output_enable_in,
      termination_cal_complete, config_request_n, st};
  endfunction
  task automatic wait_user(input int lo, hi);
    int n;
    n = 0;
    while (user_mode !== 1'b1 && n < hi) begin
      @(posedge clk);
      n++;
    end
    ck("user_delay", 1, {31'h0, n >= lo && n < hi});
  endtask
  task automatic hold_sclk(input logic v);
    repeat (6) @(posedge clk);
    repeat (10) begin
      @(posedge clk);
      ck("serial_clock", {31'h0, v}, {31'h0, serial_config_clock});
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    ck("io_oe_n", 32'hff, {24'h0, io_oe_n});
    bus(0, `OCP_OFF_CTRL, `OCP_CTRL_RESET, 0);
    bus(0, `OCP_OFF_STATUS, stat(2'h0), 0);
    bus(0, 8'h20, 32'h0, 1);
  endtask
  task automatic t_init();
    bus(1, `OCP_OFF_CTRL, 32'h42, 0);
    repeat (3) @(posedge clk);
    ck("loaded_oe_n", 0, {31'h0, init_done_oe_n});
    bus(0, `OCP_OFF_STATUS, stat(2'h1), 0);
    bus(1, `OCP_OFF_CTRL, 32'hc2, 0);
    wait_user(16, 30);
    repeat (2) @(posedge clk);
    ck("done_rise", 1, {31'h0, done_seen});
    bus(0, `OCP_OFF_STATUS, stat(2'h3), 0);
  endtask
  task automatic t_io_oe();
    bus(1, `OCP_OFF_IO_OUT, 32'h96, 0);
    bus(1, `OCP_OFF_IO_OE, 32'h5b, 0);
    repeat (2) @(posedge clk);
    ck("io_out", 32'h96, {24'h0, io_out});
    ck("io_oe_n", 32'ha4, {24'h0, io_oe_n});
    ck("pin_oe_n", 0, {31'h0, user_startup_clock_oe_n});
    ck("goe_pin_oe_n", 0, {31'h0, global_output_enable_oe_n});
    ck("gclr_pin_oe_n", 1, {31'h0, global_register_clear_n_oe_n});
    ck("pullup", 0, {31'h0, pullup_en});
    bus(1, `OCP_OFF_CTRL, 32'hca, 0);
    global_output_enable_in <= 0;
    repeat (2) @(posedge clk);
    ck("oe_sync", 32'ha4, {24'h0, io_oe_n});
    ck("goe_pin_cfg", 1, {31'h0, global_output_enable_oe_n});
    repeat (4) @(posedge clk);
    ck("oe_off", 32'hff, {24'h0, io_oe_n});
    global_output_enable_in <= 1;
    repeat (6) @(posedge clk);
    ck("oe_back", 32'ha4, {24'h0, io_oe_n});
  endtask
  task automatic t_clear();
    bus(1, `OCP_OFF_USER, 32'h3c, 0);
    bus(0, `OCP_OFF_USER, 32'h3c, 0);
    bus(1, `OCP_OFF_CTRL, 32'hd2, 0);
    global_register_clear_n_in <= 0;
    repeat (5) @(posedge clk);
    bus(0, `OCP_OFF_USER, 32'h0, 0);
    bus(1, `OCP_OFF_USER, 32'h77, 0);
    bus(0, `OCP_OFF_USER, 32'h0, 0);
    global_register_clear_n_in <= 1;
    repeat (5) @(posedge clk);
    bus(1, `OCP_OFF_USER, 32'h77, 0);
    bus(0, `OCP_OFF_USER, 32'h77, 0);
  endtask
  task automatic t_divclk();
    int n;
    logic last;
    n = 0;
    last = serial_config_clock;
    repeat (20) begin
      @(posedge clk);
      if (serial_config_clock !== last)
        n++;
      last = serial_config_clock;
    end
    ck("div_toggles", 32'h4, n);
  endtask
  task automatic reconfig();
    config_request_n <= 0;
    repeat (10) @(posedge clk);
    ck("req_oe_n", 1, {31'h0, init_done_oe_n});
    bus(1, `OCP_OFF_CTRL, 32'h0, 0);
    config_request_n <= 1;
    repeat (5) @(posedge clk);
    bus(0, `OCP_OFF_STATUS, stat(2'h0), 0);
  endtask
  task automatic t_gated(input logic [31:0] opt, input int lo, hi);
    bus(1, `OCP_OFF_CTRL, opt, 0);
    bus(1, `OCP_OFF_CTRL, opt | 32'h80, 0);
    repeat (60) @(posedge clk);
    ck("held_user", 0, {31'h0, user_mode});
    termination_cal_complete <= opt[2];
    run <= opt[0];
    wait_user(lo, hi);
    run <= 0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1;
    t_reset();
    t_init();
    t_io_oe();
    t_clear();
    t_divclk();
    bus(1, `OCP_OFF_CTRL, 32'he2, 0);
    idle_lvl <= 1;
    hold_sclk(1);
    idle_lvl <= 0;
    hold_sclk(0);
    reconfig();
    t_gated(32'h46, 0, 10);
    reconfig();
    t_gated(32'h43, 80, 120);
    tally_and_finish();
  end
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule
